// ==== rtl/reset_pin_pkg.sv ====
// Constants, register map and types for the reset pin source detector.
// Assumes a 32-bit APB master and a self-reset clock given as a tick.
package reset_pin_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] OPTS_ADDR  = 8'h00;
  localparam logic [7:0] RSTAT_ADDR = 8'h04;
  localparam logic [7:0] KBD_ADDR   = 8'h08;
  localparam logic [7:0] EVST_ADDR  = 8'h0C;
  localparam logic [7:0] EVCLR_ADDR = 8'h10;
  localparam logic [7:0] EVEN_ADDR  = 8'h14;

  // ==========================================================
  // System options register fields
  localparam int OPT_RPE     = 0;
  localparam int OPT_INTERRUPT_PIN_ENABLE   = 1;
  localparam int OPT_IRQRISE = 2;
  localparam int OPT_RTISEL  = 3;
  localparam int OPT_PORTD   = 4;
  localparam int OPT_W       = 5;
  localparam logic [OPT_W-1:0] OPTS_RESET = 5'h01;

  // ==========================================================
  // Reset status register fields
  localparam int RS_LVD  = 1;
  localparam int RS_ILAD = 3;
  localparam int RS_ILOP = 4;
  localparam int RS_COP  = 5;
  localparam int RS_PIN  = 6;
  localparam int RS_POR  = 7;
  localparam logic [7:0] RSTAT_RESET = 8'h00;

  // ==========================================================
  // Keyboard register: enables in [3:0], rising edge in [7:4], for port A pins 7..4
  localparam logic [7:0] KBD_RESET = 8'h00;

  // ==========================================================
  // Event status fields
  localparam int EV_DONE = 0;
  localparam int EV_EXT  = 1;
  localparam int EV_W    = 2;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  // ==========================================================
  // Sequence timing, in self-reset clock cycles
  localparam int DRIVE_TICKS  = 34;
  localparam int SAMPLE_TICKS = 38;
  localparam int CNT_W        = 6;
  localparam logic [CNT_W-1:0] DRIVE_LAST  = CNT_W'(DRIVE_TICKS - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_TICKS - 1);
  localparam logic [CNT_W-1:0] CNT_RESET   = 6'h00;

  typedef enum logic [1:0] {ST_DRIVE, ST_WAIT, ST_RUN} seq_state_t;

endpackage

// ==== rtl/clock_ratio.sv ====
// Clock enables for core, bus and periodic wakeup timer.
// Assumes sys_clk is the oscillator input clock.
`timescale 1ns/1ps
module clock_ratio
  import reset_pin_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clkEn,
  // Selection
  input  wire logic rtiSelOsc,
  input  wire logic rtiOscTick,
  // Enables
  output logic      coreClkEn,
  output logic      busClkEn,
  output logic      rtiClkEn
);

  logic coreNext;
  logic busNext;
  logic rtiNext;

  always_comb begin
    coreNext = 1'b1;
    busNext  = ~busClkEn;
    rtiNext  = rtiSelOsc ? rtiOscTick : 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      coreClkEn <= 1'b0;
      busClkEn  <= 1'b0;
      rtiClkEn  <= 1'b0;
    end else if (clkEn) begin
      coreClkEn <= coreNext;
      busClkEn  <= busNext;
      rtiClkEn  <= rtiNext;
    end
  end

endmodule

// ==== rtl/reset_pin_source_detect.sv ====
// Shared reset pin driver, reset source classifier and APB register file.
// Assumes pin input and reset requests are synchronous to sys_clk and that
// selfResetTick is a one-cycle pulse per self-reset clock period.
`timescale 1ns/1ps
module reset_pin_source_detect
  import reset_pin_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Self-reset tick and reset sources
  input  wire logic        selfResetTick,
  input  wire logic        lvdReq,
  input  wire logic        copReq,
  input  wire logic        ilopReq,
  input  wire logic        iladReq,
  // Shared reset pin
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  output logic             resetPullUpEn,
  // Other pin pulls
  output logic             irqPullUpEn,
  output logic             irqPullDownEn,
  output logic      [3:0]  portAPullDownEn,
  // Clocks
  input  wire logic        rtiOscTick,
  output logic             coreClkEn,
  output logic             busClkEn,
  output logic             rtiClkEn,
  // System
  output logic             systemReset,
  output logic             irq
);

  // ==========================================================
  // Cause decode
  function automatic logic [7:0] decodeCause(input logic pinLow, input logic por, input logic [3:0] cause);
    logic [7:0] r;
    r = 8'h00;
    if (pinLow) begin
      r[RS_PIN] = 1'b1;
    end else if (por) begin
      r[RS_POR] = 1'b1;
    end else if (cause[3]) begin
      r[RS_LVD] = 1'b1;
    end else if (cause[2]) begin
      r[RS_COP] = 1'b1;
    end else if (cause[1]) begin
      r[RS_ILOP] = 1'b1;
    end else if (cause[0]) begin
      r[RS_ILAD] = 1'b1;
    end else begin
      r[RS_PIN] = 1'b1;
    end
    return r;
  endfunction

  // ==========================================================
  // Sequence state
  seq_state_t       state_reg;
  seq_state_t       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [3:0]       cause_reg;
  logic [3:0]       cause_next;
  logic             por_reg;
  logic             por_next;
  logic [7:0]       rstat_reg;
  logic [7:0]       rstat_next;
  logic             doneEv;
  logic             extEv;
  logic [3:0]       reqs;

  // ==========================================================
  // Register state
  logic [OPT_W-1:0] opts_reg;
  logic [OPT_W-1:0] opts_next;
  logic [7:0]       kbd_reg;
  logic [7:0]       kbd_next;
  logic [EV_W-1:0]  evst_reg;
  logic [EV_W-1:0]  evst_next;
  logic [EV_W-1:0]  even_reg;
  logic [EV_W-1:0]  even_next;
  logic             irq_next;

  // ==========================================================
  // Bus state
  logic             accessPhase;
  logic             doWrite;
  logic             addrValid;
  logic [31:0]      readMux;
  logic [31:0]      prdata_next;
  logic             pready_next;
  logic             pslverr_next;

  // ==========================================================
  // Pin outputs
  logic             pinOut_next;
  logic             pinOe_next;
  logic             pullUp_next;
  logic             irqUp_next;
  logic             irqDown_next;
  logic [3:0]       portA_next;
  logic             sysRst_next;

  assign reqs = {lvdReq, copReq, ilopReq, iladReq};

  // ==========================================================
  // Reset sequence
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cause_next = cause_reg;
    por_next   = por_reg;
    rstat_next = rstat_reg;
    doneEv     = 1'b0;
    extEv      = 1'b0;
    unique case (state_reg)
      ST_DRIVE: begin
        if (selfResetTick) begin
          if (cnt_reg == DRIVE_LAST) begin
            cnt_next   = CNT_RESET;
            state_next = ST_WAIT;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (selfResetTick) begin
          if (cnt_reg == SAMPLE_LAST) begin
            cnt_next   = CNT_RESET;
            state_next = ST_RUN;
            rstat_next = decodeCause(!resetPinIn, por_reg, cause_reg);
            doneEv     = 1'b1;
            extEv      = !resetPinIn;
            por_next   = 1'b0;
            cause_next = 4'h0;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (|reqs) begin
          cause_next = reqs;
          state_next = ST_DRIVE;
        end else if (opts_reg[OPT_RPE] && !resetPinIn) begin
          cause_next = 4'h0;
          state_next = ST_DRIVE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_DRIVE;
      cnt_reg   <= CNT_RESET;
      cause_reg <= 4'h0;
      por_reg   <= 1'b1;
      rstat_reg <= RSTAT_RESET;
    end else if (clkEn) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cause_reg <= cause_next;
      por_reg   <= por_next;
      rstat_reg <= rstat_next;
    end
  end

  // ==========================================================
  // APB slave: one wait state, write lands on the completing edge
  always_comb begin
    accessPhase = psel && penable;
    doWrite     = accessPhase && pready && pwrite;
    addrValid   = 1'b1;
    readMux     = 32'h0000_0000;
    case (paddr)
      OPTS_ADDR:  readMux = {27'h000_0000, opts_reg};
      RSTAT_ADDR: readMux = {24'h00_0000, rstat_reg};
      KBD_ADDR:   readMux = {24'h00_0000, kbd_reg};
      EVST_ADDR:  readMux = {30'h0000_0000, evst_reg};
      EVCLR_ADDR: readMux = 32'h0000_0000;
      EVEN_ADDR:  readMux = {30'h0000_0000, even_reg};
      default:    addrValid = 1'b0;
    endcase
    pready_next  = accessPhase && !pready;
    pslverr_next = accessPhase && !pready && !addrValid;
    prdata_next  = (accessPhase && !pready && !pwrite) ? readMux : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      prdata  <= prdata_next;
      pready  <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // ==========================================================
  // Software registers and interrupt
  always_comb begin
    opts_next = opts_reg;
    kbd_next  = kbd_reg;
    even_next = even_reg;
    evst_next = evst_reg;
    if (doWrite && paddr == OPTS_ADDR) begin
      opts_next = pwdata[OPT_W-1:0];
    end
    if (doWrite && paddr == KBD_ADDR) begin
      kbd_next = pwdata[7:0];
    end
    if (doWrite && paddr == EVEN_ADDR) begin
      even_next = pwdata[EV_W-1:0];
    end
    if (doWrite && paddr == EVCLR_ADDR) begin
      evst_next = evst_reg & ~pwdata[EV_W-1:0];
    end
    // Set after clear so a same-cycle event survives
    evst_next[EV_DONE] = evst_next[EV_DONE] | doneEv;
    evst_next[EV_EXT]  = evst_next[EV_EXT] | extEv;
    // A new reset restores the options and keyboard defaults; the pin stays a reset pin throughout
    if (state_reg == ST_RUN && state_next != ST_RUN) begin
      opts_next = OPTS_RESET;
      kbd_next  = KBD_RESET;
    end
    if (state_next != ST_RUN) begin
      opts_next[OPT_RPE] = 1'b1;
    end
    irq_next = |(evst_next & even_next);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      opts_reg <= OPTS_RESET;
      kbd_reg  <= KBD_RESET;
      evst_reg <= EV_RESET;
      even_reg <= EV_RESET;
      irq      <= 1'b0;
    end else if (clkEn) begin
      opts_reg <= opts_next;
      kbd_reg  <= kbd_next;
      evst_reg <= evst_next;
      even_reg <= even_next;
      irq      <= irq_next;
    end
  end

  // ==========================================================
  // Pin drivers, from next values so they line up with the state
  always_comb begin
    // Port mode drives the output-only bit; reset mode only ever pulls low
    pinOe_next   = (state_next == ST_DRIVE) || !opts_next[OPT_RPE];
    pinOut_next  = (state_next == ST_DRIVE) ? 1'b0 : opts_next[OPT_PORTD];
    pullUp_next  = opts_next[OPT_RPE];
    irqUp_next   = opts_next[OPT_INTERRUPT_PIN_ENABLE] && !opts_next[OPT_IRQRISE];
    irqDown_next = opts_next[OPT_INTERRUPT_PIN_ENABLE] && opts_next[OPT_IRQRISE];
    portA_next   = kbd_next[3:0] & kbd_next[7:4];
    sysRst_next  = state_next != ST_RUN;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      resetPinOut     <= 1'b0;
      resetPinOe      <= 1'b1;
      resetPullUpEn   <= 1'b1;
      irqPullUpEn     <= 1'b0;
      irqPullDownEn   <= 1'b0;
      portAPullDownEn <= 4'h0;
      systemReset     <= 1'b1;
    end else if (clkEn) begin
      resetPinOut     <= pinOut_next;
      resetPinOe      <= pinOe_next;
      resetPullUpEn   <= pullUp_next;
      irqPullUpEn     <= irqUp_next;
      irqPullDownEn   <= irqDown_next;
      portAPullDownEn <= portA_next;
      systemReset     <= sysRst_next;
    end
  end

  // ==========================================================
  // Clock ratios
  clock_ratio u_clock_ratio (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .rtiSelOsc  (opts_reg[OPT_RTISEL]),
    .rtiOscTick (rtiOscTick),
    .coreClkEn  (coreClkEn),
    .busClkEn   (busClkEn),
    .rtiClkEn   (rtiClkEn)
  );

  // ==========================================================
  // Assertions
  pin_low_drive_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == ST_DRIVE |-> resetPinOe && !resetPinOut && systemReset)
    else $error("reset pin not driven low during drive phase");

  drive_end_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && selfResetTick && state_reg == ST_DRIVE && cnt_reg == DRIVE_LAST
    |=> state_reg == ST_WAIT && !resetPinOe)
    else $error("drive phase did not end after 34 ticks");

  drive_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && !selfResetTick && state_reg == ST_DRIVE |=> state_reg == ST_DRIVE && $stable(cnt_reg))
    else $error("drive counter moved without a self-reset tick");

  sample_ext_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && selfResetTick && state_reg == ST_WAIT && cnt_reg == SAMPLE_LAST && !resetPinIn
    |=> rstat_reg == 8'h40 && state_reg == ST_RUN)
    else $error("low pin at sample not recorded as external");

  sample_int_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && selfResetTick && state_reg == ST_WAIT && cnt_reg == SAMPLE_LAST && resetPinIn
    && !por_reg && cause_reg[2] && !cause_reg[3] |=> rstat_reg[RS_COP] && !rstat_reg[RS_PIN])
    else $error("internal cause not recorded");

  enable_forced_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_reg != ST_RUN |-> opts_reg[OPT_RPE] && resetPullUpEn)
    else $error("reset pin enable not set during reset");

  port_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && state_reg == ST_RUN && !opts_reg[OPT_RPE] && !resetPinIn && reqs == 4'h0
    |=> state_reg == ST_RUN)
    else $error("disabled reset pin started a reset");

  pull_up_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    resetPullUpEn == opts_reg[OPT_RPE])
    else $error("reset pull-up does not follow enable");

  irq_pull_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !opts_reg[OPT_INTERRUPT_PIN_ENABLE] |-> !irqPullUpEn && !irqPullDownEn)
    else $error("interrupt pin pull active while disabled");

  kbd_pull_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    portAPullDownEn == (kbd_reg[3:0] & kbd_reg[7:4]))
    else $error("port A pull-down mismatch");

  bus_half_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(clkEn) && $past(rstn) |-> busClkEn != $past(busClkEn))
    else $error("bus clock enable not at half rate");

endmodule

// ==== tb/reset_pin_board.sv ====
// Board model of the shared reset pin: optional pull-up and a button that can hold the pin low.
// Assumes the device drives pinOut and pinOe from sys_clk.
`timescale 1ns/1ps
module reset_pin_board (
  // Clock
  input  wire logic sys_clk,
  // Device side of the pin
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic pullUpEn,
  // Board control
  input  wire logic holdLow,
  output logic      pinLevel
);
  logic floatVal = 1'b0;

  // An undriven pin with no pull is shown as the inverse of what was last driven
  always @(posedge sys_clk) if (pinOe) floatVal <= ~pinOut;

  // The button shorts the pin to ground and wins against the device driving high
  assign pinLevel = holdLow ? 1'b0 : pinOe ? pinOut : pullUpEn ? 1'b1 : floatVal;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the reset pin source detector.
// Assumes the board model on the pin and an APB master in the tasks below.
`timescale 1ns/1ps
module tb;
  import reset_pin_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, selfResetTick = 1'b0, rtiOscTick = 1'b0;
  logic [3:0]  req = 4'h0;
  logic        holdLow = 1'b0;
  logic        clkEn = 1'b1;
  logic        pinLevel, resetPinOut, resetPinOe, resetPullUpEn, irqPullUpEn, irqPullDownEn;
  logic [3:0]  portAPullDownEn;
  logic        coreClkEn, busClkEn, rtiClkEn, systemReset, irq;
  logic [1:0]  tickDiv = 2'h0;
  logic [2:0]  rtiDiv = 3'h0;
  int          nErrors = 0;
  int          checks = 0;

  // ==========================================================
  // Clocks and ticks
  always #10 sys_clk = ~sys_clk;

  // Self-reset ticks keep running through reset
  always @(posedge sys_clk) begin
    tickDiv <= tickDiv + 2'h1;
    selfResetTick <= (tickDiv == 2'h3);
    rtiDiv <= (rtiDiv == 3'h4) ? 3'h0 : rtiDiv + 3'h1;
    rtiOscTick <= (rtiDiv == 3'h4);
  end

  // ==========================================================
  // Design and board
  reset_pin_source_detect dut (
    .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .selfResetTick(selfResetTick), .lvdReq(req[0]), .copReq(req[1]), .ilopReq(req[2]), .iladReq(req[3]),
    .resetPinIn(pinLevel), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .resetPullUpEn(resetPullUpEn), .irqPullUpEn(irqPullUpEn), .irqPullDownEn(irqPullDownEn),
    .portAPullDownEn(portAPullDownEn), .rtiOscTick(rtiOscTick), .coreClkEn(coreClkEn),
    .busClkEn(busClkEn), .rtiClkEn(rtiClkEn), .systemReset(systemReset), .irq(irq)
  );

  reset_pin_board board (
    .sys_clk(sys_clk), .pinOut(resetPinOut), .pinOe(resetPinOe),
    .pullUpEn(resetPullUpEn), .holdLow(holdLow), .pinLevel(pinLevel)
  );

  // ==========================================================
  // Shared tasks
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One idle edge first, so a released psel is never raised in the same step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(what, exp, rd);
  endtask

  task automatic settle;
    repeat (2) @(posedge sys_clk);
  endtask

  // Counts ticks seen while driving low and while waiting, then reads the cause
  task automatic run_seq(input logic [7:0] cause);
    int dt;
    int wt;
    logic high;
    dt = 0;
    wt = 0;
    high = 1'b0;
    repeat (2000) begin
      @(posedge sys_clk);
      if (rstn === 1'b1 && systemReset === 1'b1) begin
        if (resetPinOe === 1'b1) begin
          dt += selfResetTick;
          high |= (resetPinOut !== 1'b0);
        end else begin
          wt += selfResetTick;
          // Button let go at the sample edge so the next run phase sees a high pin
          if (wt == 38) holdLow <= 1'b0;
        end
      end else if (dt + wt > 0) break;
    end
    chk("driveTicks", 34, dt);
    chk("drivenLow", 0, high);
    chk("waitTicks", 38, wt);
    rdc("resetStatus", RSTAT_ADDR, cause);
  endtask

  // ==========================================================
  // Scenarios
  task automatic causes;
    logic [7:0] exp [4] = '{8'h02, 8'h20, 8'h10, 8'h08};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      req <= 4'h1 << i;
      @(posedge sys_clk);
      req <= 4'h0;
      run_seq(exp[i]);
    end
  endtask

  task automatic ext_pin;
    wr(EVCLR_ADDR, 8'h03);
    @(posedge sys_clk);
    holdLow <= 1'b1;
    run_seq(8'h40);
    wr(EVEN_ADDR, 8'h02);
    settle();
    chk("irq", 1, irq);
    wr(EVEN_ADDR, 8'h00);
    settle();
    chk("irqMasked", 0, irq);
    wr(EVEN_ADDR, 8'h02);
    settle();
    chk("irqAgain", 1, irq);
    wr(EVCLR_ADDR, 8'h02);
    settle();
    chk("irqCleared", 0, irq);
    rdc("events", EVST_ADDR, 8'h01);
  endtask

  task automatic pin_disabled;
    wr(KBD_ADDR, 8'hFF);
    wr(OPTS_ADDR, 8'h10);
    holdLow <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("systemReset", 0, systemReset);
    chk("pullUpOff", 0, resetPullUpEn);
    chk("portBit", 1, resetPinOut);
    holdLow <= 1'b0;
    @(posedge sys_clk);
    req[1] <= 1'b1;
    @(posedge sys_clk);
    req[1] <= 1'b0;
    run_seq(8'h20);
    rdc("optionsAgain", OPTS_ADDR, 8'h01);
    rdc("keyboard", KBD_ADDR, 8'h00);
  endtask

  task automatic pull_chk(input logic [7:0] opt, input logic up, input logic dn);
    wr(OPTS_ADDR, opt);
    settle();
    chk("irqPullUpEn", up, irqPullUpEn);
    chk("irqPullDownEn", dn, irqPullDownEn);
  endtask

  task automatic pulls;
    pull_chk(8'h03, 1'b1, 1'b0);
    pull_chk(8'h07, 1'b0, 1'b1);
    pull_chk(8'h05, 1'b0, 1'b0);
    wr(KBD_ADDR, 8'h3F);
    settle();
    chk("portAPullDownEn", 4'h3, portAPullDownEn);
    wr(KBD_ADDR, 8'hC3);
    settle();
    chk("portAPullDownOff", 4'h0, portAPullDownEn);
  endtask

  task automatic count_en(input logic [7:0] opt, input int eCore, input int eBus, input int eRti);
    int c;
    int b;
    int r;
    c = 0;
    b = 0;
    r = 0;
    wr(OPTS_ADDR, opt);
    settle();
    repeat (20) begin
      @(posedge sys_clk);
      c += coreClkEn;
      b += busClkEn;
      r += rtiClkEn;
    end
    chk("coreClkEn", eCore, c);
    chk("busClkEn", eBus, b);
    chk("rtiClkEn", eRti, r);
  endtask

  task automatic bus_errors;
    logic [31:0] rd;
    logic        err;
    apb(1'b0, 8'h18, 32'h0000_0000, rd, err);
    chk("pslverr", 1, err);
    chk("unmappedData", 0, rd);
    wr(RSTAT_ADDR, 8'hFF);
    rdc("statusKept", RSTAT_ADDR, 8'h20);
  endtask

  // Enable low must hold every flop, the bus clock divider included
  task automatic freeze;
    logic b;
    @(posedge sys_clk);
    clkEn <= 1'b0;
    @(posedge sys_clk);
    b = busClkEn;
    repeat (3) @(posedge sys_clk);
    chk("busFrozen", b, busClkEn);
    clkEn <= 1'b1;
    settle();
  endtask

  // A reset in mid-run with the pin in port mode must hand the pin back to reset
  task automatic mid_reset;
    wr(OPTS_ADDR, 8'h10);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("pinHeldLow", 1, resetPinOe);
    chk("resetAsserted", 1, systemReset);
    rstn <= 1'b1;
    run_seq(8'h80);
    rdc("optionsReset", OPTS_ADDR, 8'h01);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    run_seq(8'h80);
    rdc("options", OPTS_ADDR, 8'h01);
    chk("pullUpOn", 1, resetPullUpEn);
    causes();
    ext_pin();
    pin_disabled();
    pulls();
    count_en(8'h01, 20, 10, 20);
    count_en(8'h09, 20, 10, 4);
    freeze();
    bus_errors();
    mid_reset();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    wrap_up();
  end
endmodule
